// *** bench/ctrl_model.sv ***
`default_nettype none
module ctrl_model (
    output logic        k_clk,
    output logic        load_strobe_n,
    output logic        rw_sel,
    output logic [3:0]  addr,
    output logic [3:0]  byte_lane_write_n,
    output logic [35:0] data_lines_in,
    input  wire logic [35:0] data_lines_out,
    input  wire logic        data_lines_oe,
    input  wire logic        read_valid_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic run;
    // Free-running pair; complement is the falling edge
    initial begin
        run = 1'b1;
        k_clk = 1'b0;
        load_strobe_n = 1'b1;
        rw_sel = 1'b0;
        addr = 4'h0;
        byte_lane_write_n = 4'hf;
        data_lines_in = '0;
        forever begin
            #3;
            if (run) k_clk = ~k_clk;
        end
    end
    // Released lines show the inverse so stale values never match
    task automatic cmd(input logic rw, ld, input logic [3:0] a, input logic [35:0] d0, d1,
                       input logic [3:0] m0, m1, output logic [35:0] q0, q1, output logic v);
        @(posedge k_clk) #1;
        load_strobe_n = ld;
        rw_sel = rw;
        addr = a;
        @(posedge k_clk) #1;
        load_strobe_n = 1'b1;
        rw_sel = ~rw;
        addr = ~a;
        data_lines_in = d0;
        byte_lane_write_n = m0;
        // First word stands over the next rise, the second over the fall after it
        @(posedge k_clk) #1;
        data_lines_in = d1;
        byte_lane_write_n = m1;
        @(posedge k_clk) #1;
        data_lines_in = ~d1;
        byte_lane_write_n = ~m1;
        q0 = data_lines_out;
        v = read_valid_flag && data_lines_oe;
        @(negedge k_clk) #1;
        q1 = data_lines_out;
    endtask
endmodule
`default_nettype wire

// *** bench/port_sva.sv ***
`default_nettype none
module port_sva #(
    parameter int unsigned DATA_W          = 36,
    parameter int unsigned READ_LAT_HALVES = 4
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              k_clk,
    input wire logic              load_strobe_n,
    input wire logic              rw_sel,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic              data_lines_oe,
    input wire logic [1:0]        echo_timing_pair,
    input wire logic              read_valid_flag,
    input wire logic              term_data_on,
    input wire logic              term_enabled,
    input wire logic              clock_locked,
    input wire logic              timing_guaranteed,
    input wire logic              impedance_cal_pulse,
    input wire logic [7:0]        impedance_cal_count
);
    // Later variant drops data termination one half period later
    localparam int TERM_DLY = (READ_LAT_HALVES == sram_port_pkg::LAT_HALVES_2P5) ? 3 : 2;
    logic [9:0] gap_reg;
    logic [3:0] since_reg;
    // Distance from reset or last recalibration
    always_ff @(posedge mclk) begin
        if (rst || impedance_cal_pulse) begin
            gap_reg <= '0;
        end else begin
            gap_reg <= gap_reg + 10'h001;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            since_reg <= '0;
        end else if (since_reg != 4'hf) begin
            since_reg <= since_reg + 4'h1;
        end
    end
    sequence s_read_cmd;
        !load_strobe_n && rw_sel;
    endsequence
    sequence s_term_gap;
        (!term_data_on || !term_enabled) [*2];
    endsequence
    // Posedge samples show the word launched on the preceding fall
    property p_read_lat;
        @(posedge k_clk) disable iff (rst) s_read_cmd |-> ##3 (read_valid_flag && data_lines_oe);
    endproperty
    property p_quiet;
        @(posedge k_clk) disable iff (rst) (load_strobe_n || !rw_sel) |-> ##3 !read_valid_flag;
    endproperty
    property p_term_off;
        @(posedge k_clk) disable iff (rst) s_read_cmd |-> ##TERM_DLY s_term_gap;
    endproperty
    property p_valid_oe;
        @(posedge k_clk) disable iff (rst) !data_lines_oe |-> !read_valid_flag && data_lines_out == '0;
    endproperty
    property p_echo_run;
        @(edge k_clk) disable iff (rst)
            (echo_timing_pair != 2'b00 && $past(echo_timing_pair) != 2'b00)
            |-> echo_timing_pair == ~$past(echo_timing_pair);
    endproperty
    property p_cal_gap;
        @(posedge mclk) disable iff (rst) impedance_cal_pulse |-> gap_reg inside {[798:801]};
    endproperty
    property p_cal_count;
        @(posedge mclk) disable iff (rst)
            impedance_cal_pulse |-> impedance_cal_count == $past(impedance_cal_count) + 8'h01;
    endproperty
    property p_guar;
        @(posedge mclk) disable iff (rst) timing_guaranteed |-> clock_locked && $past(clock_locked);
    endproperty
    property p_term_fixed;
        @(posedge mclk) disable iff (rst) since_reg == 4'hf |-> $stable(term_enabled);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read word missing");
    a_quiet: assert property (p_quiet) else $error("valid without read");
    a_term_off: assert property (p_term_off) else $error("termination on during read");
    a_valid_oe: assert property (p_valid_oe) else $error("bus idle mismatch");
    a_echo_run: assert property (p_echo_run) else $error("echo stalled");
    a_cal_gap: assert property (p_cal_gap) else $error("recalibration spacing");
    a_cal_count: assert property (p_cal_count) else $error("recalibration count");
    a_guar: assert property (p_guar) else $error("guaranteed before lock");
    a_term_fixed: assert property (p_term_fixed) else $error("termination changed");
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, rst, k_clk, load_strobe_n, rw_sel, data_lines_oe, read_valid_flag;
    logic        die_termination_ctl, align_loop_on, term_data_on, term_lane_on, v;
    logic        term_enabled, clock_locked, timing_guaranteed, impedance_cal_pulse;
    logic [3:0]  addr, byte_lane_write_n;
    logic [35:0] data_lines_in, data_lines_out, q0, q1, e0, e1;
    logic [1:0]  echo_timing_pair;
    logic [35:0] data5;
    logic        valid5;
    logic [7:0]  impedance_cal_count;
    int          fails, n_checks;
    ddr_burst2_sram_port #(.DATA_W(36), .ADDR_W(4)) u_dut (
        .mclk(mclk), .rst(rst), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
        .rw_sel(rw_sel), .addr(addr), .byte_lane_write_n(byte_lane_write_n),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .echo_timing_pair(echo_timing_pair),
        .read_valid_flag(read_valid_flag), .die_termination_ctl(die_termination_ctl),
        .align_loop_on(align_loop_on), .term_data_on(term_data_on),
        .term_lane_on(term_lane_on), .term_enabled(term_enabled),
        .clock_locked(clock_locked), .timing_guaranteed(timing_guaranteed),
        .impedance_cal_pulse(impedance_cal_pulse), .impedance_cal_count(impedance_cal_count));
    ctrl_model u_ctrl (.k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
        .addr(addr), .byte_lane_write_n(byte_lane_write_n), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .read_valid_flag(read_valid_flag));
    // Second instance shares every input and shows the 2.5 cycle latency
    ddr_burst2_sram_port #(.DATA_W(36), .ADDR_W(4),
        .READ_LAT_HALVES(sram_port_pkg::LAT_HALVES_2P5)) u_dut5 (
        .mclk(mclk), .rst(rst), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
        .rw_sel(rw_sel), .addr(addr), .byte_lane_write_n(byte_lane_write_n),
        .data_lines_in(data_lines_in), .data_lines_out(data5), .data_lines_oe(),
        .echo_timing_pair(), .read_valid_flag(valid5),
        .die_termination_ctl(die_termination_ctl), .align_loop_on(align_loop_on),
        .term_data_on(), .term_lane_on(), .term_enabled(), .clock_locked(),
        .timing_guaranteed(), .impedance_cal_pulse(), .impedance_cal_count());
    task automatic complete_run;
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic wait_mclk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
        for (int i = 0; i < 4; i++) if (!m[i]) o[9*i +: 9] = n[9*i +: 9];
        return o;
    endfunction
    task automatic t_house;
        int i;
        i = 0;
        while (impedance_cal_pulse !== 1'b1 && i < 2000) begin
            wait_mclk(1);
            i++;
        end
        chk(36'(i >= 797 && i <= 801), 36'h1, "cal period");
        wait_mclk(1);
        chk(36'(impedance_cal_count), 36'h1, "cal count");
        wait_mclk(4);
        chk(36'(clock_locked), 36'h1, "lock");
        chk(36'(timing_guaranteed), 36'h1, "guaranteed");
        align_loop_on = 1'b0;
        wait_mclk(6);
        chk(36'(timing_guaranteed), 36'h0, "bypass");
        align_loop_on = 1'b1;
    endtask
    task automatic t_term;
        chk(36'(term_enabled), 36'h1, "strap");
        chk(36'(term_lane_on), 36'h1, "lane term");
        die_termination_ctl = 1'b0;
        wait_mclk(8);
        chk(36'(term_enabled), 36'h1, "strap held");
    endtask
    task automatic t_data;
        e0 = 36'h1_2345_6789;
        e1 = 36'hf_edcb_a987;
        u_ctrl.cmd(1'b0, 1'b0, 4'h3, e0, e1, 4'h0, 4'h0, q0, q1, v);
        u_ctrl.cmd(1'b1, 1'b0, 4'h3, '0, '0, 4'h0, 4'h0, q0, q1, v);
        chk(36'(v), 36'h1, "valid");
        chk(q0, e0, "word0");
        chk(q1, e1, "word1");
        u_ctrl.cmd(1'b0, 1'b0, 4'h3, 36'ha_aaaa_aaaa, 36'h5_5555_5555,
                   4'h5, 4'ha, q0, q1, v);
        e0 = merge(e0, 36'ha_aaaa_aaaa, 4'h5);
        e1 = merge(e1, 36'h5_5555_5555, 4'ha);
        u_ctrl.cmd(1'b0, 1'b1, 4'h3, '1, '1, 4'h0, 4'h0, q0, q1, v);
        chk(36'(v), 36'h0, "idle valid");
        u_ctrl.cmd(1'b1, 1'b0, 4'h3, '0, '0, 4'h0, 4'h0, q0, q1, v);
        chk(q0, e0, "lane word0");
        chk(q1, e1, "lane word1");
    endtask
    task automatic t_lat5;
        logic [35:0] w0;
        logic [35:0] w1;
        logic        early;
        fork
            u_ctrl.cmd(1'b1, 1'b0, 4'h3, '0, '0, 4'h0, 4'h0, q0, q1, v);
            begin
                // Command is taken at the second rise; nothing may show at the fourth
                repeat (4) @(posedge k_clk);
                #1;
                early = valid5;
                @(negedge k_clk) #1;
                w0 = data5;
                @(posedge k_clk) #1;
                w1 = data5;
            end
        join
        chk(36'(early), 36'h0, "late variant too early");
        chk(w0, e0, "late word0");
        chk(w1, e1, "late word1");
        chk(q0, e0, "early word0 again");
    endtask
    task automatic t_repower;
        wait_mclk(1);
        rst = 1'b1;
        wait_mclk(12);
        rst = 1'b0;
        chk(36'(impedance_cal_count), 36'h0, "cal count restart");
        wait_mclk(3);
        chk(36'(term_enabled), 36'h0, "strap taken again");
        chk(36'(clock_locked), 36'h0, "lock wait again");
        repeat (4) @(posedge k_clk);
        #1;
        chk(36'(term_lane_on), 36'h0, "lane term follows strap");
    endtask
    task automatic t_echo;
        @(posedge k_clk) #1;
        chk(36'(echo_timing_pair), 36'h1, "echo high");
        @(negedge k_clk) #1;
        chk(36'(echo_timing_pair), 36'h2, "echo low");
        u_ctrl.run = 1'b0;
        #20;
        e0 = 36'(echo_timing_pair);
        #20;
        chk(36'(echo_timing_pair), e0, "echo stopped");
        u_ctrl.run = 1'b1;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #100us;
        fails++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        die_termination_ctl = 1'b1;
        align_loop_on = 1'b1;
        fails = 0;
        n_checks = 0;
        repeat (12) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_house();
        t_term();
        t_data();
        t_lat5();
        t_echo();
        t_repower();
        complete_run();
    end
endmodule
bind ddr_burst2_sram_port port_sva #(.DATA_W(DATA_W), .READ_LAT_HALVES(READ_LAT_HALVES))
    u_sva (.mclk(mclk), .rst(rst),
    .k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .echo_timing_pair(echo_timing_pair), .read_valid_flag(read_valid_flag),
    .term_data_on(term_data_on), .term_enabled(term_enabled), .clock_locked(clock_locked),
    .timing_guaranteed(timing_guaranteed), .impedance_cal_pulse(impedance_cal_pulse),
    .impedance_cal_count(impedance_cal_count));
`default_nettype wire

// *** design/ddr_burst2_sram_port.sv ***
`default_nettype none
// Behaviour
// - Address is captured on the rising edge of the true input clock.
// - Every read or write is a burst of two words in one clock period.
// - Load strobe high makes the cycle idle; address is ignored.
// - With load low, select high starts a read, low starts a write.
// - Write words are captured on true then complement rising edges.
// - Read words are launched on true and complement clock phases.
// - Data bus width is a parameter of 9, 18 or 36 bits.
// - A write stores a lane only when its active-low lane enable is low.
// - Lane enables are sampled separately for each of the two words.
// - One, two or four lane enables for 9, 18 or 36 bits.
// - Echo clock rising edges track the read data outputs.
// - Echo clocks toggle continuously, also while data bus is released.
// - Echo clocks stop when the input clock pair stops.
// - Read-valid flag is high with valid read data, aligned to echo clocks.
// - Output impedance is recalibrated every 20 microseconds after power-up.
// - Loop bypass low runs without alignment loop, timing not guaranteed.
// - Termination control is latched at power-on; high enables termination.
// - After power-on the termination setting stays fixed.
// - Data termination off half cycle around reads; lane termination stays on.
module ddr_burst2_sram_port #(
    parameter int unsigned DATA_W          = sram_port_pkg::DATA_W_X36,
    parameter int unsigned ADDR_W          = 10,
    parameter int unsigned READ_LAT_HALVES = sram_port_pkg::LAT_HALVES_2P0,
    parameter int unsigned LANES           = DATA_W / sram_port_pkg::LANE_W
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   k_clk,
    input  wire logic                   load_strobe_n,
    input  wire logic                   rw_sel,
    input  wire logic [ADDR_W-1:0]      addr,
    input  wire logic [LANES-1:0]       byte_lane_write_n,
    input  wire logic [DATA_W-1:0]      data_lines_in,
    output logic      [DATA_W-1:0]      data_lines_out,
    output logic                        data_lines_oe,
    output logic      [1:0]             echo_timing_pair,
    output logic                        read_valid_flag,
    input  wire logic                   die_termination_ctl,
    input  wire logic                   align_loop_on,
    output logic                        term_data_on,
    output logic                        term_lane_on,
    output logic                        term_enabled,
    output logic                        clock_locked,
    output logic                        timing_guaranteed,
    output logic                        impedance_cal_pulse,
    output logic [sram_port_pkg::CAL_COUNT_W-1:0] impedance_cal_count
);

    localparam int unsigned LW    = DATA_W / LANES;
    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam int unsigned E     = (READ_LAT_HALVES == sram_port_pkg::LAT_HALVES_2P5) ? 1 : 0;
    localparam logic [sram_port_pkg::TIMER_W-1:0] LOCK_LAST =
        sram_port_pkg::TIMER_W'(sram_port_pkg::LOCK_CYCLES - 1);
    localparam logic [sram_port_pkg::TIMER_W-1:0] CAL_LAST =
        sram_port_pkg::TIMER_W'(sram_port_pkg::CAL_CYCLES - 1);

    // ---------------- Housekeeping domain (mclk) ----------------
    logic                                  ctl_s;
    logic                                  loop_on_s;
    logic                                  por_done_reg;
    logic                                  term_en_reg;
    logic [sram_port_pkg::TIMER_W-1:0]     lock_cnt_reg;
    logic                                  locked_reg;
    logic                                  timing_ok_reg;
    logic [sram_port_pkg::TIMER_W-1:0]     cal_cnt_reg;
    logic                                  cal_pulse_reg;
    logic [sram_port_pkg::CAL_COUNT_W-1:0] cal_count_reg;

    sync2 #(.W(2)) u_sync_pins (
        .clk (mclk),
        .d   ({die_termination_ctl, align_loop_on}),
        .q   ({ctl_s, loop_on_s})
    );

    // Strap caught once after reset release, then frozen
    always_ff @(posedge mclk) begin
        if (rst) begin
            por_done_reg <= 1'b0;
            term_en_reg  <= sram_port_pkg::TERM_EN_RST;
        end else if (!por_done_reg) begin
            por_done_reg <= 1'b1;
            term_en_reg  <= ctl_s;
        end
    end
    // no other path updates term_en_reg until the next reset

    // Lock wait restarts whenever the loop is bypassed
    always_ff @(posedge mclk) begin
        if (rst || !loop_on_s) begin
            lock_cnt_reg <= '0;
            locked_reg   <= 1'b0;
        end else if (!locked_reg) begin
            if (lock_cnt_reg == LOCK_LAST) begin
                locked_reg <= 1'b1;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            timing_ok_reg <= 1'b0;
        end else begin
            timing_ok_reg <= loop_on_s && locked_reg;
        end
    end

    // Periodic impedance recalibration, free running from power-up
    always_ff @(posedge mclk) begin
        if (rst) begin
            cal_cnt_reg   <= '0;
            cal_pulse_reg <= 1'b0;
            cal_count_reg <= sram_port_pkg::CAL_COUNT_RST;
        end else if (cal_cnt_reg == CAL_LAST) begin
            cal_cnt_reg   <= '0;
            cal_pulse_reg <= 1'b1;
            cal_count_reg <= cal_count_reg + 1'b1;
        end else begin
            cal_cnt_reg   <= cal_cnt_reg + 1'b1;
            cal_pulse_reg <= 1'b0;
        end
    end

    assign term_enabled        = term_en_reg;
    assign clock_locked        = locked_reg;
    assign timing_guaranteed   = timing_ok_reg;
    assign impedance_cal_pulse = cal_pulse_reg;
    assign impedance_cal_count = cal_count_reg;

    // ---------------- Link domain (k_clk, both edges) ----------------
    logic                 link_rst;
    logic                 term_en_k;
    logic                 term_lane_reg;
    logic [DATA_W-1:0]    mem_w0 [DEPTH];
    logic [DATA_W-1:0]    mem_w1 [DEPTH];
    logic                 rd_vld_reg [sram_port_pkg::RD_STAGES];
    logic [DATA_W-1:0]    rd_w0_reg  [sram_port_pkg::RD_STAGES];
    logic [DATA_W-1:0]    rd_w1_reg  [sram_port_pkg::RD_STAGES];
    logic                 wr0_pend_reg;
    logic [ADDR_W-1:0]    wr0_addr_reg;
    logic                 wr1_pend_reg;
    logic [ADDR_W-1:0]    wr1_addr_reg;
    sram_port_pkg::launch_t want_pos;
    sram_port_pkg::launch_t want_neg;
    sram_port_pkg::launch_t pos_flags_reg;
    sram_port_pkg::launch_t neg_flags_reg;
    sram_port_pkg::launch_t flags_out;
    logic [DATA_W-1:0]    word_pos;
    logic [DATA_W-1:0]    word_neg;
    logic [DATA_W-1:0]    data_pos_reg;
    logic [DATA_W-1:0]    data_neg_reg;

    // Reset and the static termination level enter the link domain
    sync2 #(.W(2)) u_sync_link (
        .clk (k_clk),
        .d   ({rst, term_en_reg}),
        .q   ({link_rst, term_en_k})
    );

    always_ff @(posedge k_clk) begin
        if (link_rst) begin
            term_lane_reg <= 1'b0;
        end else begin
            term_lane_reg <= term_en_k;
        end
    end

    // Command capture; idle cycles leave the pipeline empty
    always_ff @(posedge k_clk) begin
        if (link_rst) begin
            for (int s = 0; s < sram_port_pkg::RD_STAGES; s++) begin
                rd_vld_reg[s] <= 1'b0;
            end
        end else begin
            rd_vld_reg[0] <= !load_strobe_n && rw_sel;
            for (int s = 1; s < sram_port_pkg::RD_STAGES; s++) begin
                rd_vld_reg[s] <= rd_vld_reg[s-1];
            end
        end
    end

    // Both burst words fetched together at the command edge
    always_ff @(posedge k_clk) begin
        rd_w0_reg[0] <= mem_w0[addr];
        rd_w1_reg[0] <= mem_w1[addr];
        for (int s = 1; s < sram_port_pkg::RD_STAGES; s++) begin
            rd_w0_reg[s] <= rd_w0_reg[s-1];
            rd_w1_reg[s] <= rd_w1_reg[s-1];
        end
    end

    always_ff @(posedge k_clk) begin
        if (link_rst) begin
            wr0_pend_reg <= 1'b0;
            wr1_pend_reg <= 1'b0;
            wr0_addr_reg <= '0;
            wr1_addr_reg <= '0;
        end else begin
            wr0_pend_reg <= !load_strobe_n && !rw_sel;
            if (!load_strobe_n) begin
                wr0_addr_reg <= addr;
            end
            wr1_pend_reg <= wr0_pend_reg;
            wr1_addr_reg <= wr0_addr_reg;
        end
    end

    // First word on the true edge after the command, own lane mask
    always_ff @(posedge k_clk) begin
        if (!link_rst && wr0_pend_reg) begin
            for (int l = 0; l < LANES; l++) begin
                if (!byte_lane_write_n[l]) begin
                    mem_w0[wr0_addr_reg][l*LW +: LW] <= data_lines_in[l*LW +: LW];
                end
            end
        end
    end

    // Second word on the complement edge, sampled mask again
    always_ff @(negedge k_clk) begin
        if (!link_rst && wr1_pend_reg) begin
            for (int l = 0; l < LANES; l++) begin
                if (!byte_lane_write_n[l]) begin
                    mem_w1[wr1_addr_reg][l*LW +: LW] <= data_lines_in[l*LW +: LW];
                end
            end
        end
    end

    // What the bus shows after each phase; termination drops half a cycle early
    always_comb begin
        want_pos           = sram_port_pkg::LAUNCH_RST;
        want_pos.echo_true = 1'b1;
        want_pos.echo_comp = 1'b0;
        want_pos.drive     = rd_vld_reg[1+E];
        want_pos.valid     = rd_vld_reg[1+E];
        want_pos.term_data = term_en_k && !(rd_vld_reg[1] || rd_vld_reg[2]);
        word_pos           = '0;
        if (rd_vld_reg[1+E]) begin
            word_pos = (E == 1) ? rd_w1_reg[2] : rd_w0_reg[1];
        end
    end

    always_comb begin
        want_neg           = sram_port_pkg::LAUNCH_RST;
        want_neg.echo_true = 1'b0;
        want_neg.echo_comp = 1'b1;
        want_neg.drive     = rd_vld_reg[2];
        want_neg.valid     = rd_vld_reg[2];
        want_neg.term_data = term_en_k && !(rd_vld_reg[1+E] || rd_vld_reg[2+E]);
        word_neg           = '0;
        if (rd_vld_reg[2]) begin
            word_neg = (E == 1) ? rd_w0_reg[2] : rd_w1_reg[2];
        end
    end

    // Double-rate launch: each edge stores target xor other phase,
    // so the xor of the two flops shows the latest phase glitch-free
    always_ff @(posedge k_clk) begin
        if (link_rst) begin
            pos_flags_reg <= sram_port_pkg::LAUNCH_RST;
            data_pos_reg  <= '0;
        end else begin
            pos_flags_reg <= want_pos ^ neg_flags_reg;
            data_pos_reg  <= word_pos ^ data_neg_reg;
        end
    end

    always_ff @(negedge k_clk) begin
        if (link_rst) begin
            neg_flags_reg <= sram_port_pkg::LAUNCH_RST;
            data_neg_reg  <= '0;
        end else begin
            neg_flags_reg <= want_neg ^ pos_flags_reg;
            data_neg_reg  <= word_neg ^ data_pos_reg;
        end
    end

    assign flags_out           = pos_flags_reg ^ neg_flags_reg;
    assign data_lines_out      = data_pos_reg ^ data_neg_reg;
    assign data_lines_oe       = flags_out.drive;
    assign read_valid_flag     = flags_out.valid;
    assign echo_timing_pair    = {flags_out.echo_comp, flags_out.echo_true};
    assign term_data_on        = flags_out.term_data;
    assign term_lane_on        = term_lane_reg;

endmodule
`default_nettype wire

// *** design/sync2.sv ***
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end

endmodule
`default_nettype wire

// *** inc/sram_port_pkg.sv ***
`default_nettype none
package sram_port_pkg;

    // Clock of the housekeeping domain
    localparam int unsigned MCLK_HZ           = 40_000_000;
    localparam int unsigned MCLK_PER_US       = MCLK_HZ / 1_000_000;

    // Clock-alignment loop lock wait and impedance recalibration period
    localparam int unsigned LOCK_TIME_US      = 20;
    localparam int unsigned CAL_PERIOD_US     = 20;
    localparam int unsigned LOCK_CYCLES       = LOCK_TIME_US * MCLK_PER_US;
    localparam int unsigned CAL_CYCLES        = CAL_PERIOD_US * MCLK_PER_US;
    localparam int unsigned TIMER_W           = 12;

    // Read latency in half clock periods
    localparam int unsigned LAT_HALVES_2P0    = 4;
    localparam int unsigned LAT_HALVES_2P5    = 5;

    // Bus organisation
    localparam int unsigned LANE_W            = 9;
    localparam int unsigned DATA_W_X9         = 9;
    localparam int unsigned DATA_W_X18        = 18;
    localparam int unsigned DATA_W_X36        = 36;
    localparam int unsigned BURST_LEN         = 2;
    localparam int unsigned RD_STAGES         = 4;
    localparam int unsigned CAL_COUNT_W       = 8;

    // Reset values
    localparam logic        TERM_EN_RST       = 1'b0;
    localparam logic [7:0]  CAL_COUNT_RST     = 8'h00;

    // Flag outputs launched on each clock phase
    typedef struct packed {
        logic echo_true;
        logic echo_comp;
        logic valid;
        logic drive;
        logic term_data;
    } launch_t;

    localparam launch_t LAUNCH_RST = '{default: 1'b0};

endpackage
`default_nettype wire
